// >>> design/deiu_params.svh
// Register offsets, field positions and reset values of the event unit
`ifndef DEIU_PARAMS_SVH
`define DEIU_PARAMS_SVH

// Status registers, one 8-bit word each
`define DEIU_STAT0_ADDR 4'h0
`define DEIU_STAT1_ADDR 4'h1
`define DEIU_STAT2_ADDR 4'h2
`define DEIU_STAT3_ADDR 4'h3
// Mask registers, same layout as the matching status register
`define DEIU_MASK0_ADDR 4'h4
`define DEIU_MASK1_ADDR 4'h5
`define DEIU_MASK2_ADDR 4'h6
`define DEIU_MASK3_ADDR 4'h7
// Live condition readback, for inspection
`define DEIU_LIVE_ADDR 4'h8

`define DEIU_MASK_RST 8'h00
`define DEIU_STAT_RST 8'h00

// Status 0: power fail and synchronisation changes
`define DEIU_B_POWER_FAIL 0
`define DEIU_B_INTERLACE 1
`define DEIU_B_HPLL_LOCK 2
`define DEIU_B_VSYNC_LOCK 3
`define DEIU_B_FIELD_RATE 4
`define DEIU_B_CAPTURE_RDY 5
// Status 1: colour standard (two bits) and copy protection
`define DEIU_B_COLOR_STD_LO 0
`define DEIU_B_COLOR_STD_HI 1
`define DEIU_B_COPY_A 2
`define DEIU_B_COPY_B 3
`define DEIU_B_COPY_C 4
// Status 2: slicer identification
`define DEIU_B_PROG_ID 0
`define DEIU_B_WIDE_ID 1
`define DEIU_B_CAPTION_ID 2
// Status 3: scaler
`define DEIU_B_SCALER_ERR 0

`endif

// >>> design/deiu_pkg.sv
// Types shared by the event unit modules
package deiu_pkg;

  typedef logic [7:0] deiu_byte_t;

  // Raw live conditions from the decoder sections
  typedef struct packed {
    logic power_fail;
    logic interlaced;
    logic hpll_locked;
    logic vsync_locked;
    logic rate_60;
    logic capture_ready;
    logic [1:0] color_std;
    logic copy_a;
    logic copy_b;
    logic copy_c;
    logic prog_id;
    logic wide_id;
    logic caption_id;
    logic scaler_err;
  } deiu_cond_t;

endpackage : deiu_pkg

// >>> design/deiu_edge_det.sv
// Change detector for a group of live conditions
`timescale 1ns/1ps
module deiu_edge_det #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys_i, // System clock
  input wire logic srst_i, // Synchronous reset
  input wire logic [WIDTH-1:0] level_i, // Live levels
  output logic [WIDTH-1:0] change_o // One-cycle change pulses
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
    logic primed;
  } deiu_edge_st_t;

  deiu_edge_st_t st_q;
  deiu_edge_st_t st_d;

  // Hold last value; suppress a false change on the first cycle
  always_comb
  begin
    st_d = st_q;
    st_d.prev = level_i;
    st_d.primed = 1'b1;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Compare with previous cycle
  assign change_o = st_q.primed ? (level_i ^ st_q.prev) : '0;

endmodule : deiu_edge_det

// >>> design/deiu_flag_reg.sv
// One 8-bit sticky status register with mask and clear-on-read
`timescale 1ns/1ps
`include "deiu_params.svh"
module deiu_flag_reg (
  input wire logic clk_sys_i, // System clock
  input wire logic srst_i, // Synchronous reset
  input wire logic [7:0] set_i, // Event pulses
  input wire logic rd_clr_i, // Read of this status register
  input wire logic mask_we_i, // Mask write strobe
  input wire logic [7:0] mask_wd_i, // Mask write data
  output logic [7:0] flags_o, // Sticky flags
  output logic [7:0] mask_o, // Mask enables
  output logic pend_o // Any enabled flag pending
);

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] mask;
  } deiu_flag_st_t;

  deiu_flag_st_t st_q;
  deiu_flag_st_t st_d;

  // Set wins over the read clear in the same cycle
  always_comb
  begin
    st_d = st_q;
    if (rd_clr_i)
    begin
      st_d.flags = 8'h00;
    end
    st_d.flags = st_d.flags | set_i;
    if (mask_we_i)
    begin
      st_d.mask = mask_wd_i;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      st_q.flags <= `DEIU_STAT_RST;
      st_q.mask <= `DEIU_MASK_RST;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign flags_o = st_q.flags;
  assign mask_o = st_q.mask;
  assign pend_o = |(st_q.flags & st_q.mask);

endmodule : deiu_flag_reg

// >>> design/deiu_top.sv
// Decoder event interrupt unit: flags, masks, bus and request pin
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "deiu_params.svh"
module deiu_top (
  input wire logic clk_sys_i, // 25 MHz system clock
  input wire logic srst_i, // Synchronous reset, high
  input wire deiu_pkg::deiu_cond_t cond_i, // Live decoder conditions
  input wire logic [3:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  output logic irq_out_o, // Request pin level, always 0
  output logic irq_oe_o // Request pin drive enable
);

  // ****************************************************************
  // State
  // ****************************************************************

  typedef struct packed {
    logic [7:0] rdata;
    logic irq_oe;
    logic irq_out;
  } deiu_top_st_t;

  deiu_top_st_t st_q;
  deiu_top_st_t st_d;

  // ****************************************************************
  // Change detection
  // ****************************************************************

  localparam int NCOND = 14;
  logic [NCOND-1:0] lvl;
  logic [NCOND-1:0] chg;

  // Level conditions, power fail and scaler error are not edges
  assign lvl = {cond_i.interlaced, cond_i.hpll_locked, cond_i.vsync_locked,
    cond_i.rate_60, cond_i.capture_ready, cond_i.color_std,
    cond_i.copy_a, cond_i.copy_b, cond_i.copy_c, cond_i.prog_id,
    cond_i.wide_id, cond_i.caption_id, 1'b0};

  deiu_edge_det #(
    .WIDTH(NCOND)
  ) u_edge (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .level_i(lvl),
    .change_o(chg)
  );

  // ****************************************************************
  // Event mapping into the four status words
  // ****************************************************************

  logic [7:0] set0;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] set3;

  always_comb
  begin
    set0 = 8'h00;
    set1 = 8'h00;
    set2 = 8'h00;
    set3 = 8'h00;
    // Power fail is a level: it keeps re-setting while present
    set0[`DEIU_B_POWER_FAIL] = cond_i.power_fail;
    set0[`DEIU_B_INTERLACE] = chg[13];
    set0[`DEIU_B_HPLL_LOCK] = chg[12];
    set0[`DEIU_B_VSYNC_LOCK] = chg[11];
    set0[`DEIU_B_FIELD_RATE] = chg[10];
    set0[`DEIU_B_CAPTURE_RDY] = chg[9];
    // Each standard bit flags its own change, lost colour included
    set1[`DEIU_B_COLOR_STD_HI] = chg[8];
    set1[`DEIU_B_COLOR_STD_LO] = chg[7];
    set1[`DEIU_B_COPY_A] = chg[6];
    set1[`DEIU_B_COPY_B] = chg[5];
    set1[`DEIU_B_COPY_C] = chg[4];
    set2[`DEIU_B_PROG_ID] = chg[3];
    set2[`DEIU_B_WIDE_ID] = chg[2];
    set2[`DEIU_B_CAPTION_ID] = chg[1];
    set3[`DEIU_B_SCALER_ERR] = cond_i.scaler_err;
  end

  // ****************************************************************
  // Status and mask registers
  // ****************************************************************

  logic [3:0] rd_clr;
  logic [3:0] mask_we;
  logic [7:0] flags [4];
  logic [7:0] masks [4];
  logic [3:0] pend;
  logic [7:0] set_all [4];

  assign set_all[0] = set0;
  assign set_all[1] = set1;
  assign set_all[2] = set2;
  assign set_all[3] = set3;

  // Decode helper: strobe hits one of four consecutive addresses
  function automatic logic [3:0] deiu_hit4(input logic [3:0] a,
                                           input logic [3:0] base,
                                           input logic stb);
    logic [3:0] r;
    r = 4'h0;
    if (stb && a >= base && a < base + 4'h4)
    begin
      r[a[1:0]] = 1'b1;
    end
    return r;
  endfunction : deiu_hit4

  // Only a read of the owning word clears it
  assign rd_clr = deiu_hit4(addr_i, `DEIU_STAT0_ADDR, rd_i);
  assign mask_we = deiu_hit4(addr_i, `DEIU_MASK0_ADDR, wr_i);

  // Four 8-bit status words
  for (genvar g = 0; g < 4; g++)
  begin : g_reg
    deiu_flag_reg u_flag (
      .clk_sys_i(clk_sys_i),
      .srst_i(srst_i),
      .set_i(set_all[g]),
      .rd_clr_i(rd_clr[g]),
      .mask_we_i(mask_we[g]),
      .mask_wd_i(wdata_i),
      .flags_o(flags[g]),
      .mask_o(masks[g]),
      .pend_o(pend[g])
    );
  end

  // ****************************************************************
  // Read mux and request pin
  // ****************************************************************

  // Flags are returned as they stand in the strobe cycle, not a copy from the request time
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = 8'h00;
    if (rd_i)
    begin
      case (addr_i)
        `DEIU_STAT0_ADDR: st_d.rdata = flags[0];
        `DEIU_STAT1_ADDR: st_d.rdata = flags[1];
        `DEIU_STAT2_ADDR: st_d.rdata = flags[2];
        `DEIU_STAT3_ADDR: st_d.rdata = flags[3];
        `DEIU_MASK0_ADDR: st_d.rdata = masks[0];
        `DEIU_MASK1_ADDR: st_d.rdata = masks[1];
        `DEIU_MASK2_ADDR: st_d.rdata = masks[2];
        `DEIU_MASK3_ADDR: st_d.rdata = masks[3];
        `DEIU_LIVE_ADDR: st_d.rdata = {cond_i.interlaced,
          cond_i.hpll_locked, cond_i.vsync_locked, cond_i.rate_60,
          cond_i.capture_ready, cond_i.color_std, cond_i.power_fail};
        default: st_d.rdata = 8'h00;
      endcase
    end
    // Request follows pending enabled flags, one cycle late
    st_d.irq_oe = |pend;
    // Open drain only ever drives low
    st_d.irq_out = 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (srst_i)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  // Open drain: drive low only, release otherwise
  assign irq_out_o = st_q.irq_out;
  assign irq_oe_o = st_q.irq_oe;

endmodule : deiu_top

// >>> dv/deiu_host_model.sv
// Host side of the shared request line: pull-up and listener
`timescale 1ns/1ps
module deiu_host_model (
  input wire logic irq_out_i, // Unit drive level
  input wire logic irq_oe_i, // Unit drive enable
  output logic line_n_o // Resolved line, low active
);
  // Released line floats up through the board pull-up
  assign line_n_o = irq_oe_i ? irq_out_i : 1'b1;
endmodule : deiu_host_model

// >>> dv/deiu_checker.sv
// Port checks of the event unit, bound to its top
`timescale 1ns/1ps
module deiu_checker (
  input wire logic clk_sys_i, // Clock
  input wire logic srst_i, // Reset
  input wire deiu_pkg::deiu_cond_t cond_i, // Conditions
  input wire logic [3:0] addr_i, // Address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  input wire logic [7:0] rdata_o, // Read data
  input wire logic irq_out_o, // Pin level
  input wire logic irq_oe_o // Pin enable
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  logic [31:0] mask_q;
  logic clr_cause;
  // Mask mirror, so pin activity can be tied to enables
  always_ff @(posedge clk_sys_i)
    if (srst_i)
      mask_q <= '0;
    else if (wr_i && addr_i[3:2] == 2'b01)
      mask_q[addr_i[1:0]*8 +: 8] <= wdata_i;
  // Only status reads or mask writes may drop the request
  assign clr_cause = (rd_i && addr_i < 4'h4)
    || (wr_i && addr_i[3:2] == 2'b01);
  AST_PIN_LEVEL: assert property (irq_out_o == 1'b0)
    else $error("request pin driven high");
  AST_RESET_QUIET: assert property ($fell(srst_i) |->
    !irq_oe_o && rdata_o == 8'h00) else $error("not quiet after reset");
  AST_NO_MASK: assert property ((mask_q == 32'h0) [*3] |-> !irq_oe_o)
    else $error("request with all masks clear");
  AST_RISE_MASK: assert property ($rose(irq_oe_o) |->
    $past(mask_q) != 32'h0)
    else $error("request rose without enable");
  AST_PWR_RAISE: assert property ((cond_i.power_fail && mask_q[0]) [*5]
    |-> irq_oe_o) else $error("power fail not requested");
  AST_FALL_CAUSE: assert property ($fell(irq_oe_o) |-> $past(clr_cause)
    || $past(clr_cause, 2) || $past(clr_cause, 3))
    else $error("request dropped without clear");
  AST_IDLE_RDATA: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read cycle");
  AST_MASK_RB: assert property (wr_i && addr_i[3:2] == 2'b01 ##2
    rd_i && addr_i == $past(addr_i, 2) |=> rdata_o == $past(wdata_i, 3))
    else $error("mask readback differs");
endmodule : deiu_checker
bind deiu_top deiu_checker u_deiu_checker (.clk_sys_i(clk_sys_i),
  .srst_i(srst_i), .cond_i(cond_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_out_o(irq_out_o),
  .irq_oe_o(irq_oe_o));

// >>> dv/testbench.sv
// Self-checking bench for the decoder event interrupt unit
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module testbench;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  deiu_pkg::deiu_cond_t cond_i = '0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic irq_out_o;
  logic irq_oe_o;
  logic line_n;
  int n_fail = 0;
  int comparisons = 0;
  // {status register, bit} hit by each condition bit
  localparam logic [4:0] EV_MAP [15] = '{5'h18, 5'h12, 5'h11, 5'h10,
    5'h0c, 5'h0b, 5'h0a, 5'h08, 5'h09, 5'h05, 5'h04, 5'h03, 5'h02,
    5'h01, 5'h00};
  always #20 clk_sys_i = ~clk_sys_i;
  deiu_top u_deiu_top (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .cond_i(cond_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .irq_out_o(irq_out_o),
    .irq_oe_o(irq_oe_o));
  deiu_host_model u_deiu_host_model (.irq_out_i(irq_out_o),
    .irq_oe_i(irq_oe_o), .line_n_o(line_n));
  // ****************************************
  // Bus cycles and closing
  // ****************************************
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // One idle cycle after each access, so a strobe is never driven twice
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr_reg
  // Read data stand only in the cycle after the strobe edge
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    v = rdata_o;
    @(posedge clk_sys_i);
  endtask : rd_reg
  task automatic wait_low;
    int i;
    i = 0;
    while (line_n !== 1'b0 && i < 8)
    begin
      @(posedge clk_sys_i);
      i++;
    end
    if (line_n !== 1'b0)
    begin
      n_fail++;
      $display("mismatch request line expected 0 seen %b", line_n);
      tally_and_finish();
    end
  endtask : wait_low
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    logic [7:0] v;
    for (int a = 0; a < 9; a++)
    begin
      rd_reg(a[3:0], v);
      `CHK("reset value", 8'h00, v)
    end
    rd_reg(4'hf, v);
    `CHK("unmapped", 8'h00, v)
    cond_i.interlaced <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    `CHK("masked line", 1'b1, line_n)
    @(posedge clk_sys_i);
    rd_reg(4'h0, v);
    `CHK("masked flag", 8'h02, v)
    $display("test reset done");
  endtask : t_reset
  task automatic t_mask_rw;
    logic [7:0] v;
    for (int r = 0; r < 4; r++)
    begin
      wr_reg(4'h4 + r[3:0], 8'ha5 ^ r[7:0]);
      rd_reg(4'h4 + r[3:0], v);
      `CHK("mask", 8'ha5 ^ r[7:0], v)
      wr_reg(r[3:0], 8'hff);
      rd_reg(r[3:0], v);
      `CHK("status write", 8'h00, v)
      wr_reg(4'h4 + r[3:0], 8'h00);
    end
    $display("test mask_rw done");
  endtask : t_mask_rw
  // Host reads the next status word, which must be clear, then the register its single enable points at
  task automatic t_events;
    logic [7:0] v;
    logic [7:0] e;
    logic [4:0] m;
    for (int c = 0; c < 15; c++)
    begin
      m = EV_MAP[c];
      e = 8'h01 << m[2:0];
      wr_reg({2'b00, m[4:3]} + 4'h4, e);
      cond_i[c] <= ~cond_i[c];
      if (c == 0 || c == 14)
      begin
        @(posedge clk_sys_i);
        cond_i[c] <= 1'b0;
      end
      wait_low();
      rd_reg({2'b00, m[4:3] + 2'b01}, v);
      `CHK("other status", 8'h00, v)
      rd_reg({2'b00, m[4:3]}, v);
      `CHK("flag", e, v)
      rd_reg({2'b00, m[4:3]}, v);
      `CHK("cleared", 8'h00, v)
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      `CHK("released", 1'b1, line_n)
      @(posedge clk_sys_i);
      wr_reg({2'b00, m[4:3]} + 4'h4, 8'h00);
    end
    $display("test events done");
  endtask : t_events
  // Level-set flags: reads while the level stands must not clear
  task automatic t_set_wins;
    logic [7:0] v;
    logic [3:0] s;
    int c;
    for (int k = 0; k < 2; k++)
    begin
      s = (k == 0) ? 4'h0 : 4'h3;
      c = (k == 0) ? 14 : 0;
      wr_reg(s + 4'h4, 8'h01);
      cond_i[c] <= 1'b1;
      repeat (5) @(posedge clk_sys_i);
      wait_low();
      rd_reg(s, v);
      `CHK("level flag", 8'h01, v)
      rd_reg(s, v);
      `CHK("set wins", 8'h01, v)
      rd_reg(4'h8, v);
      `CHK("live", (k == 0) ? 8'h7f : 8'h7e, v)
      cond_i[c] <= 1'b0;
      rd_reg(s, v);
      `CHK("held flag", 8'h01, v)
      rd_reg(s, v);
      `CHK("dropped", 8'h00, v)
      repeat (2) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      `CHK("released", 1'b1, line_n)
      @(posedge clk_sys_i);
      wr_reg(s + 4'h4, 8'h00);
    end
    $display("test set_wins done");
  endtask : t_set_wins
  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    @(posedge clk_sys_i);
    t_reset();
    t_mask_rw();
    t_events();
    t_set_wins();
    tally_and_finish();
  end
endmodule : testbench
